/* File: sim/hcam_ct_model.sv */
`timescale 1ns/100ps
// ==========================================================
// current transformer model
// the data line is scrambled between samples, so a design that reads
// the current outside the sample pulse cannot match by luck
module hcam_ct_model (
    input wire logic aclk,
    output logic [15:0] load_current_sense_input,
    output logic current_sample_valid
);
    initial begin
        load_current_sense_input = 16'h0000;
        current_sample_valid = 1'b0;
    end

    // one sample per call; caller must let a clock edge pass before the next
    task automatic send(input logic [15:0] v);
        current_sample_valid <= 1'b1;
        load_current_sense_input <= v;
        @(posedge aclk);
        current_sample_valid <= 1'b0;
        load_current_sense_input <= ~v;
    endtask : send
endmodule : hcam_ct_model

/* File: sim/testbench.sv */
`timescale 1ns/100ps
module testbench;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic [3:0] wstrb = 4'hF;
    logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
    // bready and rready stay high: the answer is always taken at once
    logic bready = 1'b1, rready = 1'b1;
    logic heat_output_on = 1'b0, fixed_sp_mode = 1'b0;
    logic [15:0] program_setpoint = 16'h0ABC;
    logic awready, wready, bvalid, arready, rvalid, cur_vld;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [15:0] cur, control_setpoint;
    logic brk, oc, alarm1_out, lamp, flash, irq;
    int n_errors = 0;
    int checked = 0;

    initial begin
        forever #2.5 aclk = ~aclk;
    end

    hcam_ct_model u_ct (.aclk(aclk), .load_current_sense_input(cur), .current_sample_valid(cur_vld));

    hcam_top #(.ON_TIME_MIN_CYC(20)) u_dut (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
        .rresp(rresp), .rvalid(rvalid), .rready(rready), .load_current_sense_input(cur),
        .current_sample_valid(cur_vld), .heat_output_on(heat_output_on), .fixed_sp_mode(fixed_sp_mode),
        .program_setpoint(program_setpoint), .control_setpoint(control_setpoint),
        .heater_break_alarm(brk), .heater_overcurrent_alarm(oc), .alarm1_out(alarm1_out),
        .heater_alarm_lamp(lamp), .monitor_display_flash(flash), .irq(irq)
    );

    // ==========================================================
    // helpers
    task automatic summarize();
        $display("checks %0d, mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : summarize

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
        end
    endtask : chk

    // registered outputs are read in the active region, before this edge's updates land
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = hcam_pkg::RESP_OKAY);
        bit aw_ok, w_ok, b_ok;
        int n;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!b_ok && n < 100) begin
            @(posedge aclk);
            n++;
            if (bvalid) begin
                b_ok = 1;
                chk(bresp, er, "bresp");
            end
            if (!aw_ok && awready) begin
                aw_ok = 1;
                awvalid <= 1'b0;
            end
            if (!w_ok && wready) begin
                w_ok = 1;
                wvalid <= 1'b0;
            end
        end
        if (!b_ok) chk(1, 0, "write hung");
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = hcam_pkg::RESP_OKAY);
        bit r_ok;
        int n;
        araddr <= a;
        arvalid <= 1'b1;
        while (!r_ok && n < 100) begin
            @(posedge aclk);
            n++;
            if (rvalid) begin
                r_ok = 1;
                chk(rdata, e, "rdata");
                chk(rresp, er, "rresp");
            end
            if (arvalid && arready) arvalid <= 1'b0;
        end
        if (!r_ok) chk(1, 0, "read hung");
    endtask : rd

    task automatic alarms(input logic eb, input logic eo);
        @(negedge aclk);
        chk({brk, oc, alarm1_out, lamp, flash}, {eb, eo, {3{eb | eo}}}, "alarm outputs");
        @(posedge aclk);
    endtask : alarms

    task automatic samp(input logic [15:0] v, input logic eb, input logic eo);
        u_ct.send(v);
        alarms(eb, eo);
    endtask : samp

    task automatic lvl(input logic [15:0] got_sel, input logic [15:0] e);
        repeat (3) @(posedge aclk);
        @(negedge aclk);
        chk(got_sel ? control_setpoint : {15'h0000, irq}, e, "level output");
        @(posedge aclk);
    endtask : lvl

    // ==========================================================
    // scenarios
    task automatic t_reset();
        rd(hcam_pkg::OFS_CTRL, 32'h0);
        rd(hcam_pkg::OFS_BRK_THR, 32'h0);
        rd(hcam_pkg::OFS_OC_THR, 32'h1F4);
        rd(hcam_pkg::OFS_FSP, 32'h0);
        rd(hcam_pkg::OFS_SP_HI, 32'hFFFF);
        rd(hcam_pkg::OFS_IRQ_EN, 32'h0);
        rd(hcam_pkg::OFS_CUR_MON, 32'h0);
        rd(8'h40, 32'h0, hcam_pkg::RESP_SLVERR);
        wr(8'h40, 32'h1, hcam_pkg::RESP_SLVERR);
        wr(hcam_pkg::OFS_BRK_THR, 32'd600);
        rd(hcam_pkg::OFS_BRK_THR, 32'h1F4);
        $display("test reset done");
    endtask : t_reset

    task automatic t_setpoint();
        fixed_sp_mode <= 1'b1;
        wr(hcam_pkg::OFS_FSP, 32'h123);
        lvl(16'h1, 16'h0123);
        wr(hcam_pkg::OFS_SP_HI, 32'h100);
        lvl(16'h1, 16'h0100);
        fixed_sp_mode <= 1'b0;
        lvl(16'h1, 16'h0ABC);
        wr(hcam_pkg::OFS_SP_HI, 32'hFFFF);
        wr(hcam_pkg::OFS_SP_LO, 32'h200);
        rd(hcam_pkg::OFS_FSP, 32'h200);
        wr(hcam_pkg::OFS_SP_LO, 32'h0);
        $display("test setpoint done");
    endtask : t_setpoint

    task automatic t_break();
        wr(hcam_pkg::OFS_CTRL, 32'h1);
        wr(hcam_pkg::OFS_BRK_THR, 32'd100);
        samp(16'd50, 1'b0, 1'b0);
        rd(hcam_pkg::OFS_STATUS, 32'hC);
        heat_output_on <= 1'b1;
        repeat (30) @(posedge aclk);
        samp(16'd50, 1'b1, 1'b0);
        samp(16'd100, 1'b0, 1'b0);
        heat_output_on <= 1'b0;
        @(posedge aclk);
        heat_output_on <= 1'b1;
        repeat (10) @(posedge aclk);
        heat_output_on <= 1'b0;
        @(posedge aclk);
        samp(16'd50, 1'b0, 1'b0);
        heat_output_on <= 1'b1;
        repeat (30) @(posedge aclk);
        samp(16'd50, 1'b1, 1'b0);
        rd(hcam_pkg::OFS_STATUS, 32'h5);
        wr(hcam_pkg::OFS_CTRL, 32'h0);
        alarms(1'b0, 1'b0);
        wr(hcam_pkg::OFS_CTRL, 32'h1);
        wr(hcam_pkg::OFS_BRK_THR, 32'd0);
        samp(16'd0, 1'b0, 1'b0);
        wr(hcam_pkg::OFS_BRK_THR, 32'd500);
        samp(16'd600, 1'b1, 1'b0);
        wr(hcam_pkg::OFS_CTRL, 32'h5);
        wr(hcam_pkg::OFS_BRK_THR, 32'd100);
        samp(16'd200, 1'b1, 1'b0);
        wr(hcam_pkg::OFS_CTRL, 32'h1);
        samp(16'd200, 1'b0, 1'b0);
        $display("test break done");
    endtask : t_break

    task automatic t_oc();
        wr(hcam_pkg::OFS_BRK_THR, 32'd0);
        wr(hcam_pkg::OFS_OC_THR, 32'd100);
        samp(16'd200, 1'b0, 1'b0);
        wr(hcam_pkg::OFS_CTRL, 32'h2);
        wr(hcam_pkg::OFS_BRK_THR, 32'd500);
        samp(16'd101, 1'b0, 1'b1);
        samp(16'd100, 1'b0, 1'b0);
        wr(hcam_pkg::OFS_OC_THR, 32'd0);
        samp(16'd0, 1'b0, 1'b1);
        wr(hcam_pkg::OFS_OC_THR, 32'd500);
        samp(16'd600, 1'b0, 1'b0);
        $display("test overcurrent done");
    endtask : t_oc

    task automatic t_monitor();
        wr(hcam_pkg::OFS_CTRL, 32'h1);
        wr(hcam_pkg::OFS_BRK_THR, 32'd0);
        samp(16'd550, 1'b0, 1'b0);
        rd(hcam_pkg::OFS_CUR_MON, 32'd550);
        samp(16'd551, 1'b0, 1'b0);
        rd(hcam_pkg::OFS_CUR_MON, 32'hFFFF);
        rd(hcam_pkg::OFS_IRQ_STAT, 32'h7);
        wr(hcam_pkg::OFS_CTRL, 32'h0);
        rd(hcam_pkg::OFS_CUR_MON, 32'h0);
        $display("test monitor done");
    endtask : t_monitor

    task automatic t_irq();
        wr(hcam_pkg::OFS_CTRL, 32'h1);
        wr(hcam_pkg::OFS_BRK_THR, 32'd100);
        samp(16'd200, 1'b0, 1'b0);
        wr(hcam_pkg::OFS_IRQ_CLR, 32'h7);
        wr(hcam_pkg::OFS_IRQ_EN, 32'h1);
        lvl(16'h0, 16'h0);
        samp(16'd50, 1'b1, 1'b0);
        lvl(16'h0, 16'h1);
        rd(hcam_pkg::OFS_IRQ_STAT, 32'h1);
        wr(hcam_pkg::OFS_IRQ_EN, 32'h0);
        lvl(16'h0, 16'h0);
        wr(hcam_pkg::OFS_IRQ_EN, 32'h1);
        lvl(16'h0, 16'h1);
        wr(hcam_pkg::OFS_IRQ_CLR, 32'h1);
        lvl(16'h0, 16'h0);
        rd(hcam_pkg::OFS_IRQ_STAT, 32'h0);
        $display("test interrupt done");
    endtask : t_irq

    // ==========================================================
    // main sequence and watchdog
    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_reset();
        t_setpoint();
        t_break();
        t_oc();
        t_monitor();
        t_irq();
        summarize();
    end

    // the whole run needs a few hundred cycles; this is a generous margin
    initial begin
        repeat (20000) @(posedge aclk);
        n_errors++;
        $display("mismatch at %0t: watchdog expired", $time);
        summarize();
    end
endmodule : testbench

/* File: verilog/hcam_on_timer.sv */
`timescale 1ns/100ps
module hcam_on_timer #(
    parameter int unsigned MIN_CYC = hcam_pkg::ON_TIME_MIN_CYC
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic heat_on,
    output logic on_long
);
    typedef struct packed {
        logic [31:0] cnt;
        logic heat_prev;
        logic long_pulse;
    } hcam_timer_t;

    hcam_timer_t q;
    hcam_timer_t d;

    // ==========================================================
    // on time measure: verdict of the last pulse holds until the next one ends or runs past MIN_CYC
    always_comb begin
        d = q;
        d.heat_prev = heat_on;
        if (heat_on) begin
            if (q.cnt != 32'hFFFFFFFF) begin
                d.cnt = q.cnt + 32'h00000001;
            end
            // a pulse still running that is already long enough counts at once
            if (q.cnt > MIN_CYC) begin
                d.long_pulse = 1'b1;
            end
        end else begin
            d.cnt = 32'h00000000;
            if (q.heat_prev) begin
                d.long_pulse = (q.cnt > MIN_CYC);
            end
        end
        if (!aresetn) begin
            d = '0;
        end
    end

    always_ff @(posedge aclk) begin
        q <= d;
    end

    assign on_long = q.long_pulse;

endmodule : hcam_on_timer

/* File: verilog/hcam_pkg.sv */
// What this block does
// - Hold a fixed setpoint, default 0.0, bounded by the setpoint limits, driven as target only in fixed setpoint mode.
// - Take the measured heater current from the load current sense input used for break detection.
// - Suppress break and overcurrent detection while the heating output on time is 100 ms or shorter.
// - Report 0.0 to 55.0 A and show FFFF once the measured current exceeds 55.0 A.
// - Light the heater alarm lamp and flash the monitor display while either alarm is active.
// - Raise the heater break alarm when the current is below the break threshold.
// - A break threshold of 0.0 forces the break alarm off and 50.0 forces it on.
// - The break threshold spans 0.0 to 50.0 A and defaults to 0.0.
// - Raise the overcurrent alarm when the current is above the overcurrent threshold.
// - An overcurrent threshold of 50.0 forces that alarm off and 0.0 forces it on.
// - The current monitor is available only while break enable or overcurrent enable is on.
// - Break comparison runs only while heater break enable is on.
// - Overcurrent comparison runs only while overcurrent enable is on.
package hcam_pkg;

    // ==========================================================
    // currents, in units of 0.1 A
    localparam logic [15:0] CUR_MAX = 16'h0226;
    localparam logic [15:0] THR_MAX = 16'h01F4;
    localparam logic [15:0] THR_ZERO = 16'h0000;
    localparam logic [15:0] OVF_CODE = 16'hFFFF;

    // ==========================================================
    // reset values
    localparam logic [15:0] BRK_THR_RST = 16'h0000;
    localparam logic [15:0] OC_THR_RST = 16'h01F4;
    localparam logic [15:0] FSP_RST = 16'h0000;
    localparam logic [15:0] SP_LO_RST = 16'h0000;
    localparam logic [15:0] SP_HI_RST = 16'hFFFF;
    localparam logic [3:0] CTRL_RST = 4'h0;
    localparam logic [2:0] IRQ_EN_RST = 3'h0;

    // ==========================================================
    // register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_BRK_THR = 8'h04;
    localparam logic [7:0] OFS_OC_THR = 8'h08;
    localparam logic [7:0] OFS_FSP = 8'h0C;
    localparam logic [7:0] OFS_SP_LO = 8'h10;
    localparam logic [7:0] OFS_SP_HI = 8'h14;
    localparam logic [7:0] OFS_CUR_MON = 8'h18;
    localparam logic [7:0] OFS_STATUS = 8'h1C;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h20;
    localparam logic [7:0] OFS_IRQ_CLR = 8'h24;
    localparam logic [7:0] OFS_IRQ_EN = 8'h28;

    // ==========================================================
    // field positions
    localparam int CTRL_BRK_EN = 0;
    localparam int CTRL_OC_EN = 1;
    localparam int CTRL_BRK_LATCH = 2;
    localparam int CTRL_OC_LATCH = 3;
    localparam int IRQ_BRK = 0;
    localparam int IRQ_OC = 1;
    localparam int IRQ_OVF = 2;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ==========================================================
    // timing
    localparam int unsigned ON_TIME_MIN_MS = 100;
    localparam int unsigned CLK_FREQ_KHZ = 200000;
    localparam int unsigned ON_TIME_MIN_CYC = ON_TIME_MIN_MS * CLK_FREQ_KHZ;

endpackage : hcam_pkg

/* File: verilog/hcam_top.sv */
`timescale 1ns/100ps
module hcam_top #(
    parameter int unsigned ON_TIME_MIN_CYC = hcam_pkg::ON_TIME_MIN_CYC
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic [15:0] load_current_sense_input,
    input wire logic current_sample_valid,
    input wire logic heat_output_on,
    input wire logic fixed_sp_mode,
    input wire logic [15:0] program_setpoint,
    output logic [15:0] control_setpoint,
    output logic heater_break_alarm,
    output logic heater_overcurrent_alarm,
    output logic alarm1_out,
    output logic heater_alarm_lamp,
    output logic monitor_display_flash,
    output logic irq
);
    typedef struct packed {
        logic awready;
        logic wready;
        logic aw_have;
        logic w_have;
        logic [7:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic [3:0] ctrl;
        logic [15:0] brk_thr;
        logic [15:0] oc_thr;
        logic [15:0] fsp;
        logic [15:0] sp_lo;
        logic [15:0] sp_hi;
        logic [15:0] cur_mon;
        logic brk;
        logic oc;
        logic lamp;
        logic alarm1;
        logic [2:0] irq_stat;
        logic [2:0] irq_en;
        logic irq;
        logic [15:0] setpoint;
    } hcam_state_t;

    hcam_state_t q;
    hcam_state_t d;
    logic on_long;

    hcam_on_timer #(
        .MIN_CYC(ON_TIME_MIN_CYC)
    ) u_on_timer (
        .aclk(aclk),
        .aresetn(aresetn),
        .heat_on(heat_output_on),
        .on_long(on_long)
    );

    // ==========================================================
    // helpers
    function automatic logic [7:0] word_addr(input logic [7:0] a);
        word_addr = {a[7:2], 2'b00};
    endfunction : word_addr

    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] nw, input logic [3:0] strb);
        merge16 = {strb[1] ? nw[15:8] : old[15:8], strb[0] ? nw[7:0] : old[7:0]};
    endfunction : merge16

    function automatic logic [15:0] sat_thr(input logic [15:0] v);
        sat_thr = (v > hcam_pkg::THR_MAX) ? hcam_pkg::THR_MAX : v;
    endfunction : sat_thr

    // ==========================================================
    // next state
    logic avail;
    logic sample;
    logic brk_cond;
    logic oc_cond;
    logic [2:0] irq_set;
    logic [2:0] irq_clr;

    always_comb begin
        d = q;
        irq_clr = 3'h0;
        irq_set = 3'h0;
        avail = q.ctrl[hcam_pkg::CTRL_BRK_EN] | q.ctrl[hcam_pkg::CTRL_OC_EN];
        sample = current_sample_valid;

        // axi write channel: address and data taken in either order
        if (awvalid && q.awready) begin
            d.awready = 1'b0;
            d.aw_have = 1'b1;
            d.awaddr = awaddr;
        end
        if (wvalid && q.wready) begin
            d.wready = 1'b0;
            d.w_have = 1'b1;
            d.wdata = wdata;
            d.wstrb = wstrb;
        end
        if (q.aw_have && q.w_have) begin
            d.aw_have = 1'b0;
            d.w_have = 1'b0;
            d.bvalid = 1'b1;
            d.bresp = hcam_pkg::RESP_OKAY;
            case (word_addr(q.awaddr))
                hcam_pkg::OFS_CTRL: begin
                    if (q.wstrb[0]) begin
                        d.ctrl = q.wdata[3:0];
                    end
                end
                hcam_pkg::OFS_BRK_THR: d.brk_thr = sat_thr(merge16(q.brk_thr, q.wdata, q.wstrb));
                hcam_pkg::OFS_OC_THR: d.oc_thr = sat_thr(merge16(q.oc_thr, q.wdata, q.wstrb));
                hcam_pkg::OFS_FSP: d.fsp = merge16(q.fsp, q.wdata, q.wstrb);
                hcam_pkg::OFS_SP_LO: d.sp_lo = merge16(q.sp_lo, q.wdata, q.wstrb);
                hcam_pkg::OFS_SP_HI: d.sp_hi = merge16(q.sp_hi, q.wdata, q.wstrb);
                hcam_pkg::OFS_IRQ_CLR: begin
                    if (q.wstrb[0]) begin
                        irq_clr = q.wdata[2:0];
                    end
                end
                hcam_pkg::OFS_IRQ_EN: begin
                    if (q.wstrb[0]) begin
                        d.irq_en = q.wdata[2:0];
                    end
                end
                hcam_pkg::OFS_CUR_MON, hcam_pkg::OFS_STATUS, hcam_pkg::OFS_IRQ_STAT: ;
                default: d.bresp = hcam_pkg::RESP_SLVERR;
            endcase
        end
        if (q.bvalid && bready) begin
            d.bvalid = 1'b0;
            d.awready = 1'b1;
            d.wready = 1'b1;
        end

        // axi read channel
        if (arvalid && q.arready) begin
            d.arready = 1'b0;
            d.rvalid = 1'b1;
            d.rresp = hcam_pkg::RESP_OKAY;
            d.rdata = 32'h00000000;
            case (word_addr(araddr))
                hcam_pkg::OFS_CTRL: d.rdata[3:0] = q.ctrl;
                hcam_pkg::OFS_BRK_THR: d.rdata[15:0] = q.brk_thr;
                hcam_pkg::OFS_OC_THR: d.rdata[15:0] = q.oc_thr;
                hcam_pkg::OFS_FSP: d.rdata[15:0] = q.fsp;
                hcam_pkg::OFS_SP_LO: d.rdata[15:0] = q.sp_lo;
                hcam_pkg::OFS_SP_HI: d.rdata[15:0] = q.sp_hi;
                hcam_pkg::OFS_CUR_MON: d.rdata[15:0] = q.cur_mon;
                hcam_pkg::OFS_STATUS: d.rdata[3:0] = {~on_long, avail, q.oc, q.brk};
                hcam_pkg::OFS_IRQ_STAT: d.rdata[2:0] = q.irq_stat;
                hcam_pkg::OFS_IRQ_EN: d.rdata[2:0] = q.irq_en;
                hcam_pkg::OFS_IRQ_CLR: ;
                default: d.rresp = hcam_pkg::RESP_SLVERR;
            endcase
        end
        if (q.rvalid && rready) begin
            d.rvalid = 1'b0;
            d.arready = 1'b1;
        end

        // fixed setpoint kept inside the limits; limits inverted leave it at the upper one
        if (d.fsp < d.sp_lo) begin
            d.fsp = d.sp_lo;
        end
        if (d.fsp > d.sp_hi) begin
            d.fsp = d.sp_hi;
        end
        d.setpoint = fixed_sp_mode ? q.fsp : program_setpoint;

        // comparisons, forced values first; the current is the break detection input
        brk_cond = q.ctrl[hcam_pkg::CTRL_BRK_EN] && on_long
            && ((q.brk_thr == hcam_pkg::THR_MAX)
            || ((q.brk_thr != hcam_pkg::THR_ZERO) && (load_current_sense_input < q.brk_thr)));
        oc_cond = q.ctrl[hcam_pkg::CTRL_OC_EN] && on_long
            && ((q.oc_thr == hcam_pkg::THR_ZERO)
            || ((q.oc_thr != hcam_pkg::THR_MAX) && (load_current_sense_input > q.oc_thr)));

        if (sample) begin
            if (avail) begin
                d.cur_mon = (load_current_sense_input > hcam_pkg::CUR_MAX) ? hcam_pkg::OVF_CODE
                    : load_current_sense_input;
            end else begin
                d.cur_mon = 16'h0000;
            end
            irq_set[hcam_pkg::IRQ_OVF] = avail && (load_current_sense_input > hcam_pkg::CUR_MAX);
            // latch holds an alarm only while its own enable stays on
            d.brk = brk_cond || (q.ctrl[hcam_pkg::CTRL_BRK_LATCH] && q.brk);
            d.oc = oc_cond || (q.ctrl[hcam_pkg::CTRL_OC_LATCH] && q.oc);
        end
        // a stale reading must not survive the enables going off
        if (!avail) begin
            d.cur_mon = 16'h0000;
        end
        if (!q.ctrl[hcam_pkg::CTRL_BRK_EN]) begin
            d.brk = 1'b0;
        end
        if (!q.ctrl[hcam_pkg::CTRL_OC_EN]) begin
            d.oc = 1'b0;
        end
        d.lamp = d.brk | d.oc;
        d.alarm1 = d.brk | d.oc;

        // sticky events: a set in the clear cycle wins
        irq_set[hcam_pkg::IRQ_BRK] = d.brk & ~q.brk;
        irq_set[hcam_pkg::IRQ_OC] = d.oc & ~q.oc;
        d.irq_stat = (q.irq_stat & ~irq_clr) | irq_set;
        d.irq = |(d.irq_stat & d.irq_en);

        if (!aresetn) begin
            d = '0;
            d.awready = 1'b1;
            d.wready = 1'b1;
            d.arready = 1'b1;
            d.ctrl = hcam_pkg::CTRL_RST;
            d.brk_thr = hcam_pkg::BRK_THR_RST;
            d.oc_thr = hcam_pkg::OC_THR_RST;
            d.fsp = hcam_pkg::FSP_RST;
            d.sp_lo = hcam_pkg::SP_LO_RST;
            d.sp_hi = hcam_pkg::SP_HI_RST;
            d.irq_en = hcam_pkg::IRQ_EN_RST;
        end
    end

    always_ff @(posedge aclk) begin
        q <= d;
    end

    // ==========================================================
    // outputs
    assign awready = q.awready;
    assign wready = q.wready;
    assign bvalid = q.bvalid;
    assign bresp = q.bresp;
    assign arready = q.arready;
    assign rvalid = q.rvalid;
    assign rresp = q.rresp;
    assign rdata = q.rdata;
    assign control_setpoint = q.setpoint;
    assign heater_break_alarm = q.brk;
    assign heater_overcurrent_alarm = q.oc;
    assign heater_alarm_lamp = q.lamp;
    assign monitor_display_flash = q.lamp;
    assign alarm1_out = q.alarm1;
    assign irq = q.irq;

    // ==========================================================
    // checks
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sequence seq_live_sample;
        current_sample_valid && on_long;
    endsequence
    sequence seq_short_sample;
        current_sample_valid && !on_long;
    endsequence

    chk_short_quiet: assert property (
        seq_short_sample and (!q.brk && !q.oc) |=> !heater_break_alarm && !heater_overcurrent_alarm)
        else $error("alarm raised on a short heating pulse");
    chk_monitor_ovf: assert property (
        current_sample_valid && avail && load_current_sense_input > hcam_pkg::CUR_MAX
        |=> q.cur_mon == hcam_pkg::OVF_CODE)
        else $error("overflow code not shown");
    chk_lamp_flash: assert property (
        $rose(heater_break_alarm) || $rose(heater_overcurrent_alarm) |-> heater_alarm_lamp && monitor_display_flash)
        else $error("lamp or flash missing with an alarm");
    chk_break_below: assert property (
        seq_live_sample and (q.ctrl[hcam_pkg::CTRL_BRK_EN] && q.brk_thr != hcam_pkg::THR_ZERO
        && load_current_sense_input < q.brk_thr) |=> heater_break_alarm ##1 alarm1_out || !heater_break_alarm)
        else $error("break alarm missing below threshold");
    chk_break_forced: assert property (
        current_sample_valid && q.brk_thr == hcam_pkg::THR_ZERO && !q.brk |=> !heater_break_alarm)
        else $error("break alarm with zero threshold");
    chk_thr_range: assert property (
        q.brk_thr <= hcam_pkg::THR_MAX && q.oc_thr <= hcam_pkg::THR_MAX)
        else $error("threshold beyond range");
    chk_oc_above: assert property (
        seq_live_sample and (q.ctrl[hcam_pkg::CTRL_OC_EN] && q.oc_thr != hcam_pkg::THR_MAX
        && load_current_sense_input > q.oc_thr) |=> heater_overcurrent_alarm)
        else $error("overcurrent alarm missing above threshold");
    chk_oc_forced: assert property (
        current_sample_valid && q.oc_thr == hcam_pkg::THR_MAX && !q.oc |=> !heater_overcurrent_alarm)
        else $error("overcurrent alarm with full scale threshold");
    chk_mon_gate: assert property (
        current_sample_valid && !avail |=> q.cur_mon == 16'h0000)
        else $error("monitor live while disabled");
    chk_enable_gate: assert property (
        !q.ctrl[hcam_pkg::CTRL_BRK_EN] && !q.ctrl[hcam_pkg::CTRL_OC_EN] |=> !heater_break_alarm && !heater_overcurrent_alarm)
        else $error("alarm while its enable is off");
    chk_break_release: assert property (
        seq_live_sample and (!q.ctrl[hcam_pkg::CTRL_BRK_LATCH] && q.brk_thr != hcam_pkg::THR_MAX
        && load_current_sense_input >= q.brk_thr) |=> !heater_break_alarm)
        else $error("break alarm kept without latch");
    chk_alarm_one: assert property (
        $changed(heater_break_alarm | heater_overcurrent_alarm) |-> alarm1_out == (heater_break_alarm | heater_overcurrent_alarm))
        else $error("alarm one out of step");
    chk_setpoint: assert property (
        fixed_sp_mode |=> control_setpoint == $past(q.fsp))
        else $error("fixed setpoint not driven");

endmodule : hcam_top
